//--- shared/uirq_pkg.sv
// uirq_pkg: register map, field positions, reset values and frame formats for the
// serial interrupt/status block.
// assumes an AXI4-Lite slave with 32-bit data; registers sit in the low lanes.
`default_nettype none
package uirq_pkg;
   // register indices; each register owns one word at four times its index
   localparam logic [7:0] UIRQ_ENCLR_OFS  = 8'h14;
   localparam logic [7:0] UIRQ_ENSET_OFS  = 8'h16;
   localparam logic [7:0] UIRQ_FLAG_OFS   = 8'h18;
   localparam logic [7:0] UIRQ_STATUS_OFS = 8'h1a;
   localparam logic [7:0] UIRQ_DATA_OFS   = 8'h28;
   // flag and enable bit positions
   localparam int UIRQ_B_ERROR = 7;
   localparam int UIRQ_B_BRK   = 5;
   localparam int UIRQ_B_CTS   = 4;
   localparam int UIRQ_B_RXS   = 3;
   localparam int UIRQ_B_RXD   = 2;
   localparam int UIRQ_B_TXD   = 1;
   localparam int UIRQ_B_HOLD  = 0;
   // implemented enable bits (bit 6 reserved)
   localparam logic [7:0] UIRQ_EN_MASK = 8'hbf;
   // status bit positions
   localparam int UIRQ_S_TXE  = 6;
   localparam int UIRQ_S_COLLISION_FLAG = 5;
   localparam int UIRQ_S_SYNC = 4;
   localparam int UIRQ_S_CTS  = 3;
   localparam int UIRQ_S_OVF  = 2;
   localparam int UIRQ_S_FRAMING_FAULT = 1;
   localparam int UIRQ_S_PARITY_FAULT = 0;
   // reset values
   localparam logic [7:0]  UIRQ_EN_RST   = 8'h00;
   localparam logic [7:0]  UIRQ_FLAG_RST = 8'h00;
   localparam logic [15:0] UIRQ_STAT_RST = 16'h0000;
   // frame format codes
   localparam logic [3:0] UIRQ_FORM_PAR   = 4'h1;
   localparam logic [3:0] UIRQ_FORM_ABPAR = 4'h5;
   localparam logic [3:0] UIRQ_FORM_AB    = 4'h4;
   // axi response codes
   localparam logic [1:0] UIRQ_RESP_OKAY   = 2'b00;
   localparam logic [1:0] UIRQ_RESP_SLVERR = 2'b10;
endpackage : uirq_pkg
`default_nettype wire

//--- src/uirq_top.sv
// uirq_top: interrupt enable, flag and line status registers of a serial port,
// reached over AXI4-Lite.
// assumes the framing engine supplies one-cycle event pulses synchronous to aclk.
//
// Local design decision: the AXI4-Lite register port.
`default_nettype none
module uirq_top #(
   parameter int DATA_W = 9                        // received character width
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output var  logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output var  logic              s_axi_wready,
   output var  logic [1:0]        s_axi_bresp,
   output var  logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output var  logic              s_axi_arready,
   output var  logic [31:0]       s_axi_rdata,
   output var  logic [1:0]        s_axi_rresp,
   output var  logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [3:0]        frame_format_sel,        // frame format code
   input  wire logic              start_detect_enable,     // start-of-frame detection on
   input  wire logic              collision_detect_enable, // collision detection on
   input  wire logic              tx_pad_select,           // flow control pinout on
   input  wire logic              rx_enable,               // receiver enabled
   input  wire logic              cts_in,                  // clear-to-send line
   input  wire logic              ev_break,                // break character received
   input  wire logic              ev_rx_start,             // start condition on rx line
   input  wire logic              ev_collision,            // collision seen on line
   input  wire logic              ev_sync_bad,             // sync field not 0x55
   input  wire logic              ev_overflow,             // start bit with full buffer
   input  wire logic              ev_rx_char,              // character received
   input  wire logic              rx_stop_low,             // its first stop bit was low
   input  wire logic              rx_parity_bad,           // its parity was wrong
   input  wire logic [DATA_W-1:0] rx_char,                 // received character
   input  wire logic              ev_tx_idle,              // frame shifted out
   input  wire logic              tx_hold_take,            // shifter took holding data
   output var  logic              tx_data_write,           // pulse: data written
   output var  logic [DATA_W-1:0] tx_data,                 // transmit holding data
   output var  logic              irq                      // interrupt request
);
   // refuse character widths the holding registers cannot carry
   if (DATA_W < 5 || DATA_W > 16) begin : g_width_chk
      $error("uirq_top: DATA_W out of range");
   end

   logic [7:0]        en_q;          // shared enable bits
   logic [7:0]        flag_q;        // interrupt flags
   logic [5:0]        stat_q;        // sticky status: collision_flag,sync,-,ovf,framing_fault,parity_fault
   logic [DATA_W-1:0] rx_buf_q;      // received character held for software
   logic              rx_full_q;     // unread character present
   logic              hold_full_q;   // transmit holding register occupied
   logic              cts_q;         // previous cts level
   logic              cts_live_q;    // registered cts level for status

   // write channel state
   logic              aw_have_q;     // write address captured
   logic              w_have_q;      // write data captured
   logic [7:0]        aw_q;          // captured write address
   logic [31:0]       wd_q;          // captured write data
   logic [3:0]        ws_q;          // captured write strobes

   // helper: byte address of a register's own word from its index
   function automatic logic [7:0] uirq_addr(input logic [7:0] idx);
      uirq_addr = {idx[5:0], 2'b00};
   endfunction : uirq_addr

   // write accepted this cycle: both halves present, no response pending
   logic        wr_go;
   logic [7:0]  wr_word;
   always_comb begin
      wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
      wr_word = {aw_q[7:2], 2'b00};
   end

   // per-register write strobes with the selected byte
   logic       we_enclr;
   logic       we_enset;
   logic       we_flag;
   logic       we_stat;
   logic       we_data;
   logic [7:0] wb_enclr;
   logic [7:0] wb_enset;
   logic [7:0] wb_flag;
   logic [7:0] wb_stat;
   logic [DATA_W-1:0] wb_data;
   logic       wr_hit;
   always_comb begin
      we_enclr = wr_go && (wr_word == uirq_addr(uirq_pkg::UIRQ_ENCLR_OFS)) && ws_q[0];
      we_enset = wr_go && (wr_word == uirq_addr(uirq_pkg::UIRQ_ENSET_OFS)) && ws_q[0];
      we_flag  = wr_go && (wr_word == uirq_addr(uirq_pkg::UIRQ_FLAG_OFS)) && ws_q[0];
      we_stat  = wr_go && (wr_word == uirq_addr(uirq_pkg::UIRQ_STATUS_OFS)) && ws_q[0];
      we_data  = wr_go && (wr_word == uirq_addr(uirq_pkg::UIRQ_DATA_OFS)) && ws_q[0];
      wb_enclr = wd_q[7:0];
      wb_enset = wd_q[7:0];
      wb_flag  = wd_q[7:0];
      wb_stat  = wd_q[7:0];
      wb_data  = wd_q[DATA_W-1:0];
      wr_hit   = (wr_word == uirq_addr(uirq_pkg::UIRQ_ENCLR_OFS))
              || (wr_word == uirq_addr(uirq_pkg::UIRQ_ENSET_OFS))
              || (wr_word == uirq_addr(uirq_pkg::UIRQ_FLAG_OFS))
              || (wr_word == uirq_addr(uirq_pkg::UIRQ_STATUS_OFS))
              || (wr_word == uirq_addr(uirq_pkg::UIRQ_DATA_OFS));
   end

   // read of data register, taken when the read address is accepted
   logic rd_go;
   logic rd_data;
   always_comb begin
      rd_go   = s_axi_arvalid && s_axi_arready;
      rd_data = rd_go && ({s_axi_araddr[7:2], 2'b00} == uirq_addr(uirq_pkg::UIRQ_DATA_OFS));
   end

   // write address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_q      <= 8'h00;
         wd_q      <= 32'h0000_0000;
         ws_q      <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_q      <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wd_q     <= s_axi_wdata;
            ws_q     <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // ready while the slot is empty and no response is waiting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // write response, slverr for unmapped words
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= uirq_pkg::UIRQ_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? uirq_pkg::UIRQ_RESP_OKAY : uirq_pkg::UIRQ_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // shared enable bits, reached through set and clear addresses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= uirq_pkg::UIRQ_EN_RST;
      end else begin
         en_q <= (en_q | (we_enset ? (wb_enset & uirq_pkg::UIRQ_EN_MASK) : 8'h00))
                 & ~(we_enclr ? wb_enclr : 8'h00);
      end
   end

   // cts edge tracking and live level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cts_q      <= 1'b0;
         cts_live_q <= 1'b0;
      end else begin
         cts_q      <= cts_in;
         cts_live_q <= cts_in & tx_pad_select;
      end
   end

   // auto-baud and parity mode decode
   logic mode_ab;
   logic mode_par;
   logic cts_edge;
   always_comb begin
      mode_ab  = (frame_format_sel == uirq_pkg::UIRQ_FORM_AB)
              || (frame_format_sel == uirq_pkg::UIRQ_FORM_ABPAR);
      mode_par = (frame_format_sel == uirq_pkg::UIRQ_FORM_PAR)
              || (frame_format_sel == uirq_pkg::UIRQ_FORM_ABPAR);
      cts_edge = cts_q != cts_in;
   end

   // error events this cycle
   logic [5:0] err_ev;
   always_comb begin
      err_ev = 6'b00_0000;
      err_ev[uirq_pkg::UIRQ_S_COLLISION_FLAG] = ev_collision && collision_detect_enable;
      err_ev[uirq_pkg::UIRQ_S_SYNC] = ev_sync_bad && mode_ab;
      err_ev[uirq_pkg::UIRQ_S_OVF]  = ev_overflow;
      err_ev[uirq_pkg::UIRQ_S_FRAMING_FAULT] = ev_rx_char && rx_stop_low;
      err_ev[uirq_pkg::UIRQ_S_PARITY_FAULT] = ev_rx_char && rx_parity_bad && mode_par;
   end

   // sticky status bits, set wins over clear; all cleared while the receiver is off, except collision_flag and sync set by a new event
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= uirq_pkg::UIRQ_STAT_RST[5:0];
      end else if (!rx_enable) begin
         stat_q <= err_ev & 6'b11_0000;
      end else begin
         stat_q <= (stat_q & ~(we_stat ? wb_stat[5:0] & 6'b11_0111 : 6'b00_0000))
                   | err_ev;
      end
   end

   // receive holding buffer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_buf_q  <= '0;
         rx_full_q <= 1'b0;
      end else if (!rx_enable) begin
         rx_full_q <= 1'b0;
      end else if (ev_rx_char) begin
         rx_buf_q  <= rx_char;
         rx_full_q <= 1'b1;
      end else if (rd_data) begin
         rx_full_q <= 1'b0;
      end
   end

   // transmit holding register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_full_q   <= 1'b0;
         tx_data       <= '0;
         tx_data_write <= 1'b0;
      end else begin
         tx_data_write <= we_data;
         if (we_data) begin
            hold_full_q <= 1'b1;
            tx_data     <= wb_data;
         end else if (tx_hold_take) begin
            hold_full_q <= 1'b0;
         end
      end
   end

   // interrupt flags, hardware set wins over software clear, except a data write blocks the transmit-done set
   logic [7:0] fl_set;
   logic [7:0] fl_clr;
   always_comb begin
      fl_set = 8'h00;
      fl_clr = 8'h00;
      fl_set[uirq_pkg::UIRQ_B_ERROR] = |err_ev;
      fl_set[uirq_pkg::UIRQ_B_BRK]   = ev_break && mode_ab;
      fl_set[uirq_pkg::UIRQ_B_CTS]   = cts_edge;
      fl_set[uirq_pkg::UIRQ_B_RXS]   = ev_rx_start && start_detect_enable;
      fl_set[uirq_pkg::UIRQ_B_TXD]   = ev_tx_idle && !hold_full_q && !we_data;
      if (we_flag) begin
         fl_clr = wb_flag & 8'hba;
      end
      if (we_data) begin
         fl_clr[uirq_pkg::UIRQ_B_TXD] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= uirq_pkg::UIRQ_FLAG_RST;
      end else begin
         flag_q <= ((flag_q & ~fl_clr) | fl_set) & 8'hba;
      end
   end

   // live flags: receive done and holding empty follow buffer state
   logic [7:0] flag_view;
   always_comb begin
      flag_view = flag_q;
      flag_view[uirq_pkg::UIRQ_B_RXD]  = rx_full_q;
      flag_view[uirq_pkg::UIRQ_B_HOLD] = !hold_full_q;
   end

   // interrupt request from flags gated by enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flag_view & en_q);
      end
   end

   // status view, transmitter empty reads zero
   logic [15:0] stat_view;
   always_comb begin
      stat_view = 16'h0000;
      stat_view[uirq_pkg::UIRQ_S_TXE]  = 1'b0;
      stat_view[uirq_pkg::UIRQ_S_COLLISION_FLAG] = stat_q[uirq_pkg::UIRQ_S_COLLISION_FLAG];
      stat_view[uirq_pkg::UIRQ_S_SYNC] = stat_q[uirq_pkg::UIRQ_S_SYNC];
      stat_view[uirq_pkg::UIRQ_S_CTS]  = cts_live_q;
      stat_view[uirq_pkg::UIRQ_S_OVF]  = stat_q[uirq_pkg::UIRQ_S_OVF];
      stat_view[uirq_pkg::UIRQ_S_FRAMING_FAULT] = stat_q[uirq_pkg::UIRQ_S_FRAMING_FAULT];
      stat_view[uirq_pkg::UIRQ_S_PARITY_FAULT] = stat_q[uirq_pkg::UIRQ_S_PARITY_FAULT];
   end

   // read mux by word
   logic [31:0] rd_word;
   logic        rd_hit;
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case ({s_axi_araddr[7:2], 2'b00})
         uirq_addr(uirq_pkg::UIRQ_ENCLR_OFS), uirq_addr(uirq_pkg::UIRQ_ENSET_OFS): begin
            rd_word = 32'(en_q);
         end
         uirq_addr(uirq_pkg::UIRQ_FLAG_OFS): begin
            rd_word = 32'(flag_view);
         end
         uirq_addr(uirq_pkg::UIRQ_STATUS_OFS): begin
            rd_word = 32'(stat_view);
         end
         uirq_addr(uirq_pkg::UIRQ_DATA_OFS): begin
            rd_word = 32'(rx_buf_q);
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // read channel: one read at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= uirq_pkg::UIRQ_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_hit ? uirq_pkg::UIRQ_RESP_OKAY : uirq_pkg::UIRQ_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule : uirq_top
`default_nettype wire

//--- verif/uirq_top_assertions.sv
// uirq_top_checker: bus and register checks on the ports of uirq_top.
// assumes a bind into uirq_top and a synchronous active-low reset.
`default_nettype none
module uirq_top_checker #(
   parameter int DATA_W = 9                   // character width
) (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic [7:0]        s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              tx_pad_select,
   input wire logic              cts_in,
   input wire logic              tx_data_write,
   input wire logic [DATA_W-1:0] tx_data,
   input wire logic              irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  rd_addr_q;                    // address of the read in flight
   logic [31:0] wdata_q;                      // last accepted write data
   localparam logic [7:0] STAT_A = uirq_pkg::UIRQ_STATUS_OFS << 2; // status word address
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // keep the read address for judging the answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_addr_q <= 8'h00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_q <= s_axi_araddr;
      end
   end
   // keep write data for judging the transmit holding value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdata_q <= 32'h0000_0000;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wdata_q <= s_axi_wdata;
      end
   end
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_cts_quiet;
      $stable(cts_in) [*6];
   endsequence
   chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer missing");
   chk_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write answer missing");
   chk_write_busy: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while busy");
   chk_unmapped_err: assert property ($rose(s_axi_rvalid) && rd_addr_q < 8'h50
      |-> s_axi_rresp == uirq_pkg::UIRQ_RESP_SLVERR) else $error("unmapped read not refused");
   chk_txe_zero: assert property (s_axi_rvalid && rd_addr_q == STAT_A
      |-> s_axi_rdata[6] == 1'b0 && s_axi_rdata[31:8] == 24'h00_0000) else $error("txe bit set");
   chk_cts_live: assert property (s_cts_quiet ##0 ($rose(s_axi_rvalid) && tx_pad_select
      && rd_addr_q == STAT_A) |-> s_axi_rdata[3] == cts_in)
      else $error("cts level wrong");
   chk_tx_pulse: assert property (tx_data_write |=> !tx_data_write)
      else $error("data write pulse too long");
   chk_tx_value: assert property (tx_data_write |-> tx_data == wdata_q[DATA_W-1:0])
      else $error("transmit data differs from write");
   chk_irq_reset: assert property (disable iff (1'b0) !aresetn |=> !irq)
      else $error("irq high after reset");
endmodule : uirq_top_checker
bind uirq_top uirq_top_checker #(.DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

//--- verif/uirq_peer.sv
// uirq_peer: far-side serial engine, line events as one-cycle pulses.
// assumes tasks are called just after a rising edge of aclk.
`default_nettype none
module uirq_peer #(
   parameter int DATA_W = 9                      // character width
) (
   input  wire logic              aclk,
   input  wire logic              tx_data_write, // holding register loaded
   output var  logic              cts_in,        // clear-to-send level
   output var  logic              ev_break,
   output var  logic              ev_rx_start,
   output var  logic              ev_collision,
   output var  logic              ev_sync_bad,
   output var  logic              ev_overflow,
   output var  logic              ev_rx_char,    // character complete
   output var  logic              rx_stop_low,
   output var  logic              rx_parity_bad,
   output var  logic [DATA_W-1:0] rx_char,
   output var  logic              ev_tx_idle,    // frame shifted out
   output var  logic              tx_hold_take   // shifter took holding data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] ev_q = 5'h00;                     // one-hot line events
   int         hold_gap = 20;                    // cycles before the shifter takes data
   initial begin
      {cts_in, ev_rx_char, rx_stop_low, rx_parity_bad, ev_tx_idle, tx_hold_take} = '0;
      rx_char = '1;
   end
   assign ev_break     = ev_q[0];
   assign ev_rx_start  = ev_q[1];
   assign ev_collision = ev_q[2];
   assign ev_sync_bad  = ev_q[3];
   assign ev_overflow  = ev_q[4];
   // one event pulse of kind k
   task automatic pulse(input int k);
      @(posedge aclk);
      ev_q[k] <= 1'b1;
      @(posedge aclk);
      ev_q <= 5'h00;
   endtask : pulse
   task automatic set_cts(input logic v);
      @(posedge aclk);
      cts_in <= v;
   endtask : set_cts
   // a character with its qualifiers; lines show the inverse once released
   task automatic send_char(input logic [DATA_W-1:0] c, input logic s, input logic p);
      @(posedge aclk);
      rx_char <= c;
      rx_stop_low <= s;
      rx_parity_bad <= p;
      ev_rx_char <= 1'b1;
      @(posedge aclk);
      rx_char <= ~c;
      rx_stop_low <= ~s;
      rx_parity_bad <= ~p;
      ev_rx_char <= 1'b0;
   endtask : send_char
   // shifter takes the holding data late, then ends the frame
   always @(posedge aclk) begin
      if (tx_data_write) begin
         repeat (hold_gap) @(posedge aclk);
         tx_hold_take <= 1'b1;
         @(posedge aclk);
         tx_hold_take <= 1'b0;
         repeat (10) @(posedge aclk);
         ev_tx_idle <= 1'b1;
         @(posedge aclk);
         ev_tx_idle <= 1'b0;
      end
   end
endmodule : uirq_peer
`default_nettype wire

//--- verif/uirq_top_test.sv
// uirq_top_test: register-level tests of the interrupt and status block.
// assumes uirq_peer supplies the line events; an AXI4-Lite master is below.
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin num_errors++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module uirq_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DW = 9;                                   // character width
   localparam logic [7:0] A_EN = uirq_pkg::UIRQ_ENCLR_OFS << 2; // enable clear, set at +8
   localparam logic [7:0] A_FL = uirq_pkg::UIRQ_FLAG_OFS << 2;  // flags, status at +8
   localparam logic [7:0] A_DA = uirq_pkg::UIRQ_DATA_OFS << 2;  // data word
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic start_detect_enable, collision_detect_enable, tx_pad_select, rx_enable;
   logic cts_in, ev_break, ev_rx_start, ev_collision, ev_sync_bad, ev_overflow, ev_rx_char;
   logic rx_stop_low, rx_parity_bad, ev_tx_idle, tx_hold_take, tx_data_write;
   logic [7:0]    s_axi_awaddr, s_axi_araddr, en_exp;
   logic [31:0]   s_axi_wdata, s_axi_rdata, rd_q;
   logic [3:0]    s_axi_wstrb, frame_format_sel;
   logic [1:0]    s_axi_bresp, s_axi_rresp, resp_q;
   logic [DW-1:0] rx_char, tx_data;
   int num_errors, comparisons, cycles;
   int bits[7] = '{7, 5, 4, 3, 2, 1, 0};                    // implemented enable bits
   // expected {status, flag} per peer event kind
   logic [31:0] ev_tab[5] = '{32'h0000_0020, 32'h0000_0008, 32'h0020_0080, 32'h0010_0080,
                              32'h0004_0080};
   uirq_top #(.DATA_W(DW)) dut (.*);
   uirq_peer #(.DATA_W(DW)) peer (.*);
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   // one write; aw and w released as each is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      resp_q = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
   endtask : rd
   task automatic chkrd(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
      logic [15:0] lo;                                      // first register of the pair
      rd(a);
      lo = rd_q[15:0];
      rd(a + 8'h08);
      `CHK(nm, e, {rd_q[15:0], lo} & m)
   endtask : chkrd
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // hang guard
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         wrap_up();
      end
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {start_detect_enable, collision_detect_enable, tx_pad_select, frame_format_sel} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      rx_enable = 1'b1;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      chkrd("enables", A_EN, 32'h00ff_00ff, 32'h0000_0000);
      chkrd("flags", A_FL, 32'h00ff_00ff, 32'h0000_0001);
      wr(A_FL, 32'h0000_0001, 4'b0001);
      chkrd("hold", A_FL, 32'h0000_0001, 32'h0000_0001);
      en_exp = 8'h00;
      foreach (bits[i]) begin
         wr(A_EN + 8'h08, 32'h0000_0001 << bits[i], 4'b0001);
         en_exp[bits[i]] = 1'b1;
         chkrd("set", A_EN, 32'h00ff_00ff, {8'h00, en_exp, 8'h00, en_exp});
      end
      `CHK("irq on", 1'b1, irq)
      foreach (bits[i]) begin
         wr(A_EN, 32'h0000_0001 << bits[i], 4'b0001);
         en_exp[bits[i]] = 1'b0;
         chkrd("clear", A_EN, 32'h00ff_00ff, {8'h00, en_exp, 8'h00, en_exp});
      end
      `CHK("irq off", 1'b0, irq)
      // line events gated off: no flag may rise
      for (int k = 0; k < 4; k++) peer.pulse(k);
      chkrd("gated", A_FL, 32'h00f7_00fe, 32'h0000_0000);
      frame_format_sel <= uirq_pkg::UIRQ_FORM_AB;
      collision_detect_enable <= 1'b1;
      start_detect_enable <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         peer.pulse(k);
         chkrd("event", A_FL, 32'h00f7_00fe, ev_tab[k]);
         wr(A_FL, ev_tab[k], 4'b0001);
         wr(A_FL + 8'h08, ev_tab[k] >> 16, 4'b0001);
         chkrd("w1c", A_FL, 32'h00f7_00fe, 32'h0000_0000);
      end
      tx_pad_select <= 1'b1;
      peer.set_cts(1'b1);
      chkrd("cts", A_FL, 32'h0008_0010, 32'h0008_0010);
      wr(A_FL, 32'h0000_0010, 4'b0001);
      wr(A_FL + 8'h08, 32'h0000_0048, 4'b0001);
      chkrd("cts w1c", A_FL, 32'h0048_0010, 32'h0008_0000);
      frame_format_sel <= uirq_pkg::UIRQ_FORM_PAR;
      peer.send_char(9'h1a5, 1'b1, 1'b1);
      chkrd("rx err", A_FL, 32'h0007_0084, 32'h0003_0084);
      wr(A_FL, 32'h0000_0084, 4'b0001);
      chkrd("rx keep", A_FL, 32'h0003_0084, 32'h0003_0004);
      rd(A_DA);
      `CHK("rx data", 9'h1a5, rd_q[8:0])
      chkrd("rx read", A_FL, 32'h0000_0004, 32'h0000_0000);
      peer.send_char(9'h03c, 1'b0, 1'b0);
      rx_enable <= 1'b0;
      @(posedge aclk);
      rx_enable <= 1'b1;
      chkrd("rx off", A_FL, 32'h0037_0004, 32'h0000_0000);
      wr(A_DA, 32'h0000_0155, 4'b0001);
      chkrd("tx busy", A_FL, 32'h0000_0003, 32'h0000_0000);
      `CHK("tx data", 9'h155, tx_data)
      repeat (60) @(posedge aclk);
      chkrd("tx done", A_FL, 32'h0000_0003, 32'h0000_0003);
      wr(A_DA, 32'h0000_00aa, 4'b0001);
      chkrd("tx new", A_FL, 32'h0000_0003, 32'h0000_0000);
      repeat (60) @(posedge aclk);
      wr(A_FL, 32'h0000_0003, 4'b0001);
      chkrd("tx w1c", A_FL, 32'h0000_0003, 32'h0000_0001);
      wr(8'h40, 32'h0000_00ff, 4'b1111);
      `CHK("bresp", uirq_pkg::UIRQ_RESP_SLVERR, resp_q)
      rd(8'h40);
      `CHK("rresp", uirq_pkg::UIRQ_RESP_SLVERR, resp_q)
      wrap_up();
   end
endmodule : uirq_top_test
`default_nettype wire
